// >>> src/lpo_pkg.sv
// package: register map, field layout and mode codes of the pixel output formatter
package lpo_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [3:0] LPO_OFF_CTRL   = 4'h0;    // device control word
    localparam logic [3:0] LPO_OFF_STATUS = 4'h4;    // formatter status word
    localparam logic [3:0] LPO_OFF_PIXEL  = 4'h8;    // pixel word offset, not decoded by lpo_top: reads zero, writes ignored
    // control field positions
    localparam int LPO_POS_ORDER  = 1;   // output order field [2:1]
    localparam int LPO_POS_PACK   = 3;   // deep colour packing [4:3]
    localparam int LPO_POS_DEVICE = 5;   // device type [7:5]
    localparam int LPO_POS_LINE   = 17;  // line order [18:17]
    localparam int LPO_POS_BUSSEL = 28;  // deep colour bus select
    localparam int LPO_POS_DEPTH  = 24;  // colour depth [25:24]
    localparam int LPO_POS_WORD   = 26;  // bus width word
    localparam logic [31:0] LPO_CTRL_RESET = 32'h0000_00E0;  // mpu module device by default
    localparam logic [31:0] LPO_CTRL_MASK  = 32'h1706_00FE;  // implemented bits
    // device type codes
    localparam logic [2:0] LPO_DEV_YUV422 = 3'h0;
    localparam logic [2:0] LPO_DEV_YUV444 = 3'h1;
    localparam logic [2:0] LPO_DEV_SUBA   = 3'h4;
    localparam logic [2:0] LPO_DEV_SUBB   = 3'h5;
    localparam logic [2:0] LPO_DEV_HICOL  = 3'h6;
    localparam logic [2:0] LPO_DEV_MPU    = 3'h7;
    // colour depth codes
    localparam logic [1:0] LPO_D4K   = 2'h0;
    localparam logic [1:0] LPO_D64K  = 2'h1;
    localparam logic [1:0] LPO_D256K = 2'h2;
    localparam logic [1:0] LPO_D16M  = 2'h3;
    // pixel words are 24 bits: r[23:16] g[15:8] b[7:0], left aligned components
    localparam int LPO_BUS_W = 18;
    // formatter states
    typedef enum logic [2:0] {
        LPO_IDLE = 3'b001,
        LPO_LOAD = 3'b010,
        LPO_SEND = 3'b100
    } lpo_state_t;
endpackage : lpo_pkg

// >>> src/lpo_beat.sv
// beat selector: forms one bus transfer from the held pixels and mode
`timescale 1ns/1ns
`default_nettype none
module lpo_beat (
    input  wire logic [2:0]  device,      // device type
    input  wire logic [1:0]  depth,       // colour depth
    input  wire logic [1:0]  order,       // output order field
    input  wire logic [1:0]  pack,        // deep colour packing
    input  wire logic        word,        // bus width word
    input  wire logic        bus_sel,     // deep colour bus select (8/16 when 1)
    input  wire logic [1:0]  line_ord,    // line order field
    input  wire logic        odd_line,    // current line parity
    input  wire logic [23:0] pix0,        // current pixel
    input  wire logic [23:0] pix1,        // next pixel (pairs)
    input  wire logic [2:0]  beat,        // beat index in group
    input  wire logic [1:0]  subc,        // sub-sample component counter
    output logic      [17:0] data,        // bus value
    output logic      [2:0]  last_beat,   // final beat index of group
    output logic             two_pix      // group consumes two pixels
);
    // component picker: 0 r, 1 g, 2 b
    function automatic logic [7:0] comp(input logic [23:0] p, input logic [1:0] c);
        case (c)
            2'h0:    comp = p[23:16];
            2'h1:    comp = p[15:8];
            default: comp = p[7:0];
        endcase
    endfunction : comp
    // component at position k of the line order for this line
    function automatic logic [1:0] lseq(input logic [1:0] lo, input logic odd,
                                        input logic [1:0] k);
        logic [5:0] s;
        s = 6'h0;
        case ({lo, odd})
            3'b000: s = 6'b10_01_00;  // first line rgb
            3'b001: s = 6'b00_10_01;  // second line gbr
            3'b010: s = 6'b00_01_10;  // first line bgr
            3'b011: s = 6'b01_00_10;  // second line brg
            3'b100: s = 6'b00_10_01;  // gbr
            3'b101: s = 6'b10_01_00;  // rgb
            3'b110: s = 6'b01_10_00;  // rbg
            default: s = 6'b00_01_10; // bgr
        endcase
        case (k)
            2'h0:    lseq = s[1:0];
            2'h1:    lseq = s[3:2];
            default: lseq = s[5:4];
        endcase
    endfunction : lseq
    logic [15:0] p565;   // rgb565 of pix0
    logic [17:0] p666;   // rgb666 of pix0
    logic [11:0] p444;   // rgb444 of pix0
    logic [11:0] q444;   // rgb444 of pix1
    logic [7:0]  hi8;    // first byte of 565 after swap
    logic [7:0]  lo8;    // second byte of 565 after swap
    assign p565 = {pix0[23:19], pix0[15:10], pix0[7:3]};
    assign p666 = {pix0[23:18], pix0[15:10], pix0[7:2]};
    assign p444 = {pix0[23:20], pix0[15:12], pix0[7:4]};
    assign q444 = {pix1[23:20], pix1[15:12], pix1[7:4]};
    assign hi8  = order[0] ? p565[7:0]  : p565[15:8];
    assign lo8  = order[0] ? p565[15:8] : p565[7:0];
    // transfer formation per device, depth and width
    always_comb begin
        data      = 18'h0_0000;
        last_beat = 3'h0;
        two_pix   = 1'b0;
        case (device)
            lpo_pkg::LPO_DEV_YUV422, lpo_pkg::LPO_DEV_YUV444: begin
                // y in r lane, u in g lane, v in b lane; pair pix0/pix1
                two_pix   = 1'b1;
                last_beat = 3'h3;
                case ({order, beat[1:0]})  // see RULE1
                    4'h0, 4'hA, 4'h5, 4'hF: data = {10'h0, pix0[15:8]};   // u
                    4'h2, 4'h8, 4'h7, 4'hD: data = {10'h0, pix0[7:0]};    // v
                    4'h1, 4'h4, 4'h9, 4'hC: data = {10'h0, pix0[23:16]};  // first y
                    default:                data = {10'h0, pix1[23:16]};  // second y
                endcase
            end
            lpo_pkg::LPO_DEV_SUBA, lpo_pkg::LPO_DEV_SUBB: begin
                if (depth == lpo_pkg::LPO_D16M && word) begin
                    // one component per pixel, order from line field
                    data = {10'h0, comp(pix0, lseq(line_ord, odd_line, subc))};  // see RULE16
                    if (order[1])
                        last_beat = (subc == 2'h0) ? 3'h1 : 3'h0;  // see RULE3
                    else
                        last_beat = 3'h0;  // see RULE2
                end else begin
                    // half-word: 2 or 3 components per pixel
                    last_beat = order[0] ? 3'h2 : 3'h1;  // see RULE4
                    data = {10'h0, comp(pix0, lseq(line_ord, odd_line,
                                                   beat[1:0] + subc))};
                end
            end
            lpo_pkg::LPO_DEV_HICOL: begin
                if (depth == lpo_pkg::LPO_D16M) begin
                    last_beat = order[1] ? 3'h3 : 3'h2;  // see RULE5
                    data = (beat == 3'h3) ? 18'h0_0000
                                          : {10'h0, comp(pix0, beat[1:0])};
                end else if (depth == lpo_pkg::LPO_D64K) begin
                    last_beat = 3'h1;  // see RULE6
                    data = {10'h0, beat[0] ? lo8 : hi8};
                end else begin
                    last_beat = 3'h1;  // see RULE6
                    data = {9'h0, (beat[0] ^ order[0]) ? p666[8:0] : p666[17:9]};
                end
            end
            default: begin
                // mpu module
                case (depth)  // see RULE18
                    lpo_pkg::LPO_D4K: begin
                        if (word) begin
                            data = order[1] ? {6'h0, p444} : {2'h0, p444, 4'h0};  // see RULE8 RULE10
                        end else begin
                            two_pix   = 1'b1;
                            last_beat = 3'h2;  // see RULE9
                            case (beat[1:0])
                                2'h0:    data = {10'h0, p444[11:4]};
                                2'h1:    data = {10'h0, p444[3:0], q444[11:8]};
                                default: data = {10'h0, q444[7:0]};
                            endcase
                        end
                    end
                    lpo_pkg::LPO_D64K: begin
                        if (word) begin
                            data = {2'h0, p565};  // see RULE11
                        end else begin
                            last_beat = 3'h1;  // see RULE7 RULE11
                            data = {10'h0, beat[0] ? lo8 : hi8};
                        end
                    end
                    default: begin
                        if (!bus_sel) begin
                            if (word) begin
                                data = p666;  // see RULE15
                            end else begin
                                last_beat = 3'h1;  // see RULE7 RULE13
                                data = {9'h0, (beat[0] ^ order[0]) ? p666[8:0]
                                                                   : p666[17:9]};
                            end
                        end else if (word) begin
                            last_beat = 3'h1;  // see RULE14
                            case ({pack, beat[0]})
                                3'b000: data = {2'h0, p666[17:2]};
                                3'b001: data = {16'h0, p666[1:0]};
                                3'b010: data = {16'h0, p666[17:16]};
                                3'b011: data = {2'h0, p666[15:0]};
                                3'b100, 3'b110: data = {2'h0, p666[17:12], 2'h0,
                                                        p666[11:6], 2'h0};
                                3'b101: data = {2'h0, 8'h0, p666[5:0], 2'h0};
                                default: data = {2'h0, p666[5:0], 10'h0};
                            endcase
                        end else begin
                            last_beat = 3'h2;  // see RULE12
                            if (!pack[0]) begin
                                data = {10'h0, comp(pix0, beat[1:0])} & 18'h0_00FC;
                            end else begin
                                case (beat[1:0])
                                    2'h0:    data = {10'h0, p666[17:10]};
                                    2'h1:    data = {10'h0, p666[9:2]};
                                    default: data = {16'h0, p666[1:0]};
                                endcase
                            end
                        end
                    end
                endcase
            end
        endcase
    end
endmodule : lpo_beat
`default_nettype wire

// >>> src/lpo_top.sv
// pixel output formatter: wishbone registers, pixel intake and bus sequencing
//
// What this block does
// RULE1: yuv order code picks UYVY YUYV VYUY YVYU
// RULE2: sub-sample word mode: one component per pixel
// RULE3: order bit1: two then one, 1.5 cycles
// RULE4: half-word sub-sample: 2 or 3 cycles per pixel
// RULE5: high-colour 16M: RGB or RGB plus dummy
// RULE6: high-colour 565/666: bit0 picks which half first
// RULE7: mpu 565/666 narrow bus: bit0 picks half first
// RULE8: mpu 16-bit 4096: bit1 picks justification
// RULE9: 12-bit on 8-bit: two pixels, three transfers
// RULE10: 12-bit on 16-bit: one justified transfer
// RULE11: 16-bit pixel: two bytes, or one word
// RULE12: 18-bit on 8-bit: three transfers, packing select
// RULE13: 18-bit on 9-bit: two nine-bit halves
// RULE14: 18-bit on 16-bit: four padded arrangements
// RULE15: 18-bit on 18-bit: single transfer
// RULE16: 24-bit sub-sample: line field orders components
// RULE17: device type field selects output device
// RULE18: colour depth field selects colour count
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module lpo_top (
    input  wire logic        clk_sys,       // system clock, 20 MHz
    input  wire logic        reset,         // synchronous, active high
    input  wire logic        wb_cyc_i,      // wishbone cycle
    input  wire logic        wb_stb_i,      // wishbone strobe
    input  wire logic        wb_we_i,       // write enable
    input  wire logic [3:0]  wb_adr_i,      // byte address
    input  wire logic [3:0]  wb_sel_i,      // byte lanes
    input  wire logic [31:0] wb_dat_i,      // write data
    output logic      [31:0] wb_dat_o,      // read data
    output logic             wb_ack_o,      // acknowledge
    input  wire logic        pix_valid,     // display fifo has a pixel
    input  wire logic [23:0] pix_data,      // pixel r g b
    output logic             pix_ready,     // pixel taken at the previous edge
    input  wire logic        line_start,    // pulse: new line begins
    output logic      [17:0] pixel_data_bus,// display data bus
    output logic             pixel_strobe   // one transfer on the bus
);
    // control register and derived fields
    logic [31:0] ctrl_ff;          // device control word
    logic [2:0]  device;           // see RULE17
    logic [1:0]  depth;            // colour depth select
    logic [1:0]  order;            // output order field
    logic [1:0]  pack;             // deep colour packing
    logic        word;             // bus width word
    logic        bus_sel;          // deep colour bus select
    logic [1:0]  line_ord;         // line order field
    assign device   = ctrl_ff[lpo_pkg::LPO_POS_DEVICE +: 3];  // see RULE17
    assign depth    = ctrl_ff[lpo_pkg::LPO_POS_DEPTH +: 2];   // see RULE18
    assign order    = ctrl_ff[lpo_pkg::LPO_POS_ORDER +: 2];
    assign pack     = ctrl_ff[lpo_pkg::LPO_POS_PACK +: 2];
    assign word     = ctrl_ff[lpo_pkg::LPO_POS_WORD];
    assign bus_sel  = ctrl_ff[lpo_pkg::LPO_POS_BUSSEL];
    assign line_ord = ctrl_ff[lpo_pkg::LPO_POS_LINE +: 2];

    // sequencer state
    lpo_pkg::lpo_state_t state_ff;   // formatter state
    lpo_pkg::lpo_state_t nxt_state;  // next state
    logic [23:0] pix0_ff;            // current pixel
    logic [23:0] pix1_ff;            // second pixel of a pair
    logic        have0_ff;           // first of pair loaded
    logic [2:0]  beat_ff;            // beat index
    logic [1:0]  subc_ff;            // sub-sample phase
    logic        odd_line_ff;        // line parity
    logic [15:0] pix_cnt_ff;         // pixels consumed, wraps
    logic [17:0] beat_data;          // formed bus value
    logic [2:0]  last_beat;          // last beat in group
    logic        two_pix;            // group needs two pixels
    logic        take;               // fifo handshake
    logic        sending;            // beat goes onto the bus next cycle
    logic        grp_end;            // final beat of group

    // bus slave signals
    logic        wb_req;             // new request, not yet acked
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // transfer formation
    lpo_beat u_beat (
        .device    (device),
        .depth     (depth),
        .order     (order),
        .pack      (pack),
        .word      (word),
        .bus_sel   (bus_sel),
        .line_ord  (line_ord),
        .odd_line  (odd_line_ff),
        .pix0      (pix0_ff),
        .pix1      (pix1_ff),
        .beat      (beat_ff),
        .subc      (subc_ff),
        .data      (beat_data),
        .last_beat (last_beat),
        .two_pix   (two_pix)
    );

    assign take    = (state_ff == lpo_pkg::LPO_IDLE) && pix_valid && !pix_ready;
    assign sending = (state_ff == lpo_pkg::LPO_SEND);
    assign grp_end = sending && (beat_ff == last_beat);

    // control register writes, byte lanes honoured
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff <= lpo_pkg::LPO_CTRL_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == lpo_pkg::LPO_OFF_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i])
                    ctrl_ff[8*i +: 8] <= wb_dat_i[8*i +: 8] & lpo_pkg::LPO_CTRL_MASK[8*i +: 8];
            end
        end
    end

    // bus answer: ack one cycle after request, reads mux registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    lpo_pkg::LPO_OFF_CTRL:   wb_dat_o <= ctrl_ff;
                    lpo_pkg::LPO_OFF_STATUS: wb_dat_o <= {12'h000, odd_line_ff,
                                                          state_ff, pix_cnt_ff};
                    default:                 wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // state transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            lpo_pkg::LPO_IDLE: if (take && (!two_pix || have0_ff)) nxt_state = lpo_pkg::LPO_SEND;
            lpo_pkg::LPO_SEND: if (grp_end) nxt_state = lpo_pkg::LPO_IDLE;
            default:           nxt_state = lpo_pkg::LPO_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset)
            state_ff <= lpo_pkg::LPO_IDLE;
        else
            state_ff <= nxt_state;
    end

    // pixel capture; pairs fill pix0 then pix1
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pix0_ff    <= 24'h00_0000;
            pix1_ff    <= 24'h00_0000;
            have0_ff   <= 1'b0;
            pix_ready  <= 1'b0;
            pix_cnt_ff <= 16'h0000;
        end else begin
            pix_ready <= take;
            if (take) begin
                pix_cnt_ff <= pix_cnt_ff + 16'h0001;
                if (two_pix && have0_ff) begin
                    pix1_ff  <= pix_data;
                    have0_ff <= 1'b0;
                end else begin
                    pix0_ff  <= pix_data;
                    have0_ff <= two_pix;
                end
            end
        end
    end

    // beat counter and sub-sample phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            beat_ff <= 3'h0;
            subc_ff <= 2'h0;
        end else if (line_start) begin
            beat_ff <= 3'h0;
            subc_ff <= 2'h0;
        end else if (grp_end) begin
            beat_ff <= 3'h0;
            // phase advances by last_beat[0] plus one, mod three
            if (subc_ff + {1'b0, last_beat[0]} >= 2'h2)  // see RULE2 RULE3
                subc_ff <= subc_ff + {1'b0, last_beat[0]} - 2'h2;
            else
                subc_ff <= subc_ff + {1'b0, last_beat[0]} + 2'h1;
        end else if (sending) begin
            beat_ff <= beat_ff + 3'h1;
        end
    end

    // line parity toggles at each line start
    always_ff @(posedge clk_sys) begin
        if (reset)
            odd_line_ff <= 1'b0;
        else if (line_start)
            odd_line_ff <= !odd_line_ff;  // see RULE16
    end

    // registered bus outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pixel_data_bus <= 18'h0_0000;
            pixel_strobe   <= 1'b0;
        end else begin
            pixel_strobe <= sending;
            if (sending)
                pixel_data_bus <= beat_data;
        end
    end

    // ack follows a request by exactly one cycle
    property p_ack_once;
        @(posedge clk_sys) disable iff (reset)
        wb_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("wishbone ack not one cycle");

    // mpu 565 narrow bus gives two strobes per pixel
    property p_two_beats;
        @(posedge clk_sys) disable iff (reset)
        (take && device == lpo_pkg::LPO_DEV_MPU && depth == lpo_pkg::LPO_D64K && !word)
        |=> sending ##1 sending ##1 !sending;
    endproperty
    a_two_beats: assert property (p_two_beats) else $error("565 not two beats"); // see RULE11

    // high-colour 16M dummy mode gives four beats
    property p_four_beats;
        @(posedge clk_sys) disable iff (reset)
        (take && device == lpo_pkg::LPO_DEV_HICOL && depth == lpo_pkg::LPO_D16M && order[1])
        |=> sending [*4] ##1 !sending;
    endproperty
    a_four_beats: assert property (p_four_beats) else $error("rgbx not four beats"); // see RULE5

    // 18-bit bus sends one beat per pixel
    property p_one_beat;
        @(posedge clk_sys) disable iff (reset)
        (take && device == lpo_pkg::LPO_DEV_MPU && depth == lpo_pkg::LPO_D256K
         && word && !bus_sel) |=> sending ##1 !sending;
    endproperty
    a_one_beat: assert property (p_one_beat) else $error("18-bit not one beat"); // see RULE15

    // strobe mirrors a send beat one cycle later
    property p_strobe;
        @(posedge clk_sys) disable iff (reset)
        sending |=> pixel_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe missing after beat");

    // 4096 on 16-bit right justified keeps top bits clear
    property p_just;
        @(posedge clk_sys) disable iff (reset)
        (sending && device == lpo_pkg::LPO_DEV_MPU && depth == lpo_pkg::LPO_D4K
         && word && order[1]) |=> pixel_data_bus[15:12] == 4'h0;
    endproperty
    a_just: assert property (p_just) else $error("4096 justification wrong"); // see RULE8

    // half-word sub-sample with bit0 set gives three beats
    property p_three;
        @(posedge clk_sys) disable iff (reset)
        (take && device == lpo_pkg::LPO_DEV_SUBA && !word && order == 2'h1)
        |=> sending [*3] ##1 !sending;
    endproperty
    a_three: assert property (p_three) else $error("sub-sample not three beats"); // see RULE4

    // word sub-sample without bit1 gives one beat per pixel
    property p_sub1;
        @(posedge clk_sys) disable iff (reset)
        (take && device == lpo_pkg::LPO_DEV_SUBA && word && depth == lpo_pkg::LPO_D16M
         && !order[1]) |=> sending ##1 !sending;
    endproperty
    a_sub1: assert property (p_sub1) else $error("sub-sample not one beat"); // see RULE2

    // a group of three, or of four, back to back sends and then a gap
    sequence s_three_sends;
        sending [*3] ##1 !sending;
    endsequence
    sequence s_four_sends;
        sending [*4] ##1 !sending;
    endsequence

    // a yuv pixel pair goes out as four bytes
    property p_yuv_group;
        @(posedge clk_sys) disable iff (reset)
        (take && have0_ff && device == lpo_pkg::LPO_DEV_YUV422) |=> s_four_sends;
    endproperty
    a_yuv_group: assert property (p_yuv_group) else $error("yuv pair not four beats"); // see RULE1

    // yuyv puts the luma of the second pixel in the third byte
    property p_yuyv_luma;
        @(posedge clk_sys) disable iff (reset)
        (sending && device == lpo_pkg::LPO_DEV_YUV422 && order == 2'h1
         && beat_ff == 3'h2) |=> pixel_data_bus[7:0] == $past(pix1_ff[23:16]);
    endproperty
    a_yuyv_luma: assert property (p_yuyv_luma) else $error("yuyv luma order wrong"); // see RULE1

    // two 12-bit pixels on the byte bus take three beats
    property p_pair12;
        @(posedge clk_sys) disable iff (reset)
        (take && have0_ff && device == lpo_pkg::LPO_DEV_MPU && depth == lpo_pkg::LPO_D4K
         && !word) |=> s_three_sends;
    endproperty
    a_pair12: assert property (p_pair12) else $error("12-bit pair not three beats"); // see RULE9
endmodule : lpo_top
`default_nettype wire

// >>> verif/lpo_panel_model.sv
// panel model: captures each bus transfer strobed by the formatter
`timescale 1ns/1ns
`default_nettype none
module lpo_panel_model (
    input  wire logic        clk_sys,        // system clock
    input  wire logic        clear,          // empties the capture list
    input  wire logic [17:0] pixel_data_bus, // display data bus
    input  wire logic        pixel_strobe,   // one transfer on the bus
    output logic      [17:0] beats [0:7],    // captured transfers in order
    output logic      [2:0]  count_ff        // transfers captured so far
);
    // latch a transfer on every strobe while clear is low, as a panel would
    always_ff @(posedge clk_sys) begin
        if (clear) begin
            count_ff <= 3'h0;
        end else if (pixel_strobe) begin
            beats[count_ff] <= pixel_data_bus;
            count_ff        <= count_ff + 3'h1;
        end
    end
endmodule : lpo_panel_model
`default_nettype wire

// >>> verif/tb_lpo_top.sv
// testbench: register access and per-mode transfer checks
`timescale 1ns/1ns
`default_nettype none
module tb_lpo_top;
    logic        clk_sys = 1'b0;  // 20 MHz clock
    logic        reset   = 1'b1;  // held for ten cycles
    logic        req     = 1'b0;  // cyc and stb together
    logic        we      = 1'b0;  // write enable
    logic [3:0]  adr     = 4'h0;  // byte address
    logic [31:0] wdat    = 32'h0; // write data
    logic [31:0] rdat;            // read data
    logic        ack;             // acknowledge
    logic        pv      = 1'b0;  // pixel valid
    logic [23:0] pd      = 24'h0; // pixel value
    logic        pr;              // pixel taken
    logic [17:0] bus;             // display bus
    logic        stb;             // transfer strobe
    logic        clr     = 1'b1;  // model clear
    logic [17:0] beats [0:7];     // captured transfers
    logic [2:0]  cnt;             // captured count
    logic [31:0] q;               // read result
    int          miscompares = 0;
    int          total_checks = 0;
    // mode table: control word, transfer count, first and second transfer
    logic [31:0] tc [0:8] = '{32'h0500_00E0, 32'h0100_00E0, 32'h0100_00E2,
        32'h0400_00E0, 32'h0400_00E4, 32'h0300_00C0, 32'h0300_00C4,
        32'h0200_00E0, 32'h0600_00E0};
    logic [31:0] tn [0:8] = '{32'h1, 32'h2, 32'h2, 32'h1, 32'h1, 32'h3, 32'h4, 32'h2, 32'h1};
    logic [17:0] t0 [0:8] = '{18'h0_AAA7, 18'h0_00AA, 18'h0_00A7, 18'h0_A530,
        18'h0_0A53, 18'h0_00A8, 18'h0_00A8, 18'h0_0152, 18'h2_A54E};
    logic [17:0] t1 [0:8] = '{18'h0_AAA7, 18'h0_00A7, 18'h0_00AA, 18'h0_A530,
        18'h0_0A53, 18'h0_0054, 18'h0_0054, 18'h0_014E, 18'h2_A54E};
    lpo_top dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pix_valid(pv), .pix_data(pd), .pix_ready(pr),
        .line_start(1'b0), .pixel_data_bus(bus), .pixel_strobe(stb));
    lpo_panel_model pm_u (.clk_sys(clk_sys), .clear(clr), .pixel_data_bus(bus),
        .pixel_strobe(stb), .beats(beats), .count_ff(cnt));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic final_report;
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waits rising edges for a flag, bounded
    task automatic wait_hi(ref logic f);
        int n;
        n = 0;
        while (f !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 20) chk(32'h0, 32'h1);
        if (n == 20) final_report();
    endtask : wait_hi
    // classic single wishbone cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        wait_hi(ack);
        q = rdat;
        req <= 1'b0;
    endtask : wb
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0000_00E0);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, 4'h0, tc[i]);
            wb(1'b0, 4'h0, 32'h0);
            chk(q, tc[i]);
            @(posedge clk_sys);
            clr <= 1'b0;
            pv  <= 1'b1;
            pd  <= 24'hA8_5438;
            wait_hi(pr);
            pv <= 1'b0;
            repeat (10) @(posedge clk_sys);
            chk({29'h0, cnt}, tn[i]);
            chk({14'h0, beats[0]}, {14'h0, t0[i]});
            chk({14'h0, beats[tn[i] > 1]}, {14'h0, t1[i]});
            clr <= 1'b1;
        end
        final_report();
    end
endmodule : tb_lpo_top
`default_nettype wire
